// ==== logic/ssig_gate.sv ====
// Six-source interrupt gate with enable mask, third-timer flags and idle wake
`timescale 1ns/10ps

// How it works
// - Six sources exist, each with its own vector number 0 to 5.
// - Each source has its own enable bit that software sets or clears.
// - Bit 7 of the enable mask is a global gate; while low nothing is acknowledged.
// - Enables sit at bit 5 timer C, 4 serial, 3 timer B, 2 line B, 1 timer A, 0 line A.
// - An enable bit of one admits its source and zero blocks it.
// - The timer C request is the OR of its overflow flag and its external flag.
// - Timer C flags stay set on vectoring; the service routine clears them.
// - Timer A and B flags are set at state5_phase2 and polled the next machine cycle.
// - The timer C overflow flag is set at state2_phase2 and polled that same cycle.
// - In idle the gate keeps detecting and polling and keeps its registers.
// - Idle ends when an enabled request is pending, or on hardware reset.
// - Power-down is left only by hardware reset; no interrupt ends it.
// - With external enable set and up/down mode off, a falling edge on the timer C input sets its external flag.
// - In up/down mode the toggling external flag raises no request.
// - In baud mode a timer C rollover does not set the overflow flag.
module ssig_gate (
  input wire logic sys_clk, // 10 MHz core clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire ssig_pkg::ssig_ahb_in_t ahb_in, // AHB-Lite slave inputs
  output ssig_pkg::ssig_ahb_out_t ahb_out, // AHB-Lite slave outputs
  input wire logic ext_request_line_a_n, // Pin, request while low
  input wire logic ext_request_line_b_n, // Pin, request while low
  input wire logic timer_c_external_input, // Pin, falling edge event
  input wire logic timer_a_rollover, // One-cycle pulse from timer A
  input wire logic timer_b_rollover, // One-cycle pulse from timer B
  input wire logic timer_c_rollover, // One-cycle pulse from timer C
  input wire logic serial_request, // Level from the serial port
  input wire logic idle_request, // Core pulse entering idle
  input wire logic powerdown_request, // Core pulse entering power-down
  input wire logic core_ack, // Core takes the offered vector
  output ssig_pkg::ssig_vec_t vec_out, // Offered vector, held until taken
  output logic cpu_halted, // High in idle and power-down
  output logic osc_stopped, // High in power-down
  output logic irq // Level: enabled sticky status set
);
  import ssig_pkg::*;

  // Two-stage synchronisers for the three pins
  logic [2:0] sync1, sync2;
  logic tcx_prev;
  logic [3:0] phase, next_phase;
  logic [7:0] interrupt_enable_mask, next_ie;
  logic [7:0] timer_c_control_reg, next_tcc;
  logic [5:0] stat, next_stat, ien, next_ien;
  logic ta_pend, tb_pend, tc_pend, next_ta_pend, next_tb_pend, next_tc_pend;
  logic timer_a_overflow_flag, timer_b_overflow_flag, next_ta_flag, next_tb_flag;
  ssig_vec_t next_vec;
  ssig_pwr_t pwr, next_pwr;
  logic ap_valid, ap_write, next_ap_valid, next_ap_write;
  logic [7:0] ap_addr, next_ap_addr;
  logic [31:0] hrdata, next_hrdata;
  logic [5:0] raw_req, enabled_req;
  logic tc_fall, wr_ie, wr_tcc, poll, acked;
  logic [5:0] disp;

  // Lowest set index wins; fixed order keeps one vector per poll
  function automatic logic [2:0] pick(input logic [5:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Decoded read value of one register
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] ie,
                                         input logic [7:0] tcc, input logic [5:0] st,
                                         input logic [5:0] en, input logic [1:0] pw);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == ADDR_IE) begin
      d = {24'h00_0000, ie};
    end else if (a == ADDR_TCC) begin
      d = {24'h00_0000, tcc};
    end else if (a == ADDR_STAT) begin
      d = {26'h000_0000, st};
    end else if (a == ADDR_IEN) begin
      d = {26'h000_0000, en};
    end else if (a == ADDR_PWR) begin
      d = {30'h0000_0000, pw};
    end
    return d;
  endfunction

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      tcx_prev <= 1'b1;
    end else begin
      sync1 <= {timer_c_external_input, ext_request_line_b_n, ext_request_line_a_n};
      sync2 <= sync1;
      tcx_prev <= sync2[2];
    end
  end

  assign tc_fall = tcx_prev & ~sync2[2];
  // Requests in vector order; up/down mode hides the toggling flag
  assign raw_req = {timer_c_control_reg[TCC_OVF] |
                    (timer_c_control_reg[TCC_EXT] & ~timer_c_control_reg[TCC_UPDOWN]),
                    serial_request, timer_b_overflow_flag, ~sync2[1],
                    timer_a_overflow_flag, ~sync2[0]};
  // Global gate over individual enables
  assign enabled_req = raw_req & interrupt_enable_mask[5:0] &
                       {6{interrupt_enable_mask[IE_GLOBAL]}};
  // Polling stops with the oscillator stopped and while a vector is offered
  assign poll = (phase == PH_STATE5_PHASE2) && (pwr != SSIG_PDOWN) && !vec_out.valid;
  assign acked = vec_out.valid && core_ack;
  assign disp = (poll && enabled_req != 6'h00) ? 6'(6'h01 << pick(enabled_req)) : 6'h00;
  assign wr_ie = ap_valid && ap_write && ap_addr == ADDR_IE;
  assign wr_tcc = ap_valid && ap_write && ap_addr == ADDR_TCC;

  // Bus address phase capture and read data; zero wait states
  always_comb begin
    next_ap_valid = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
    next_ap_write = ahb_in.hwrite;
    next_ap_addr = ahb_in.haddr[7:0];
    next_hrdata = hrdata;
    if (next_ap_valid && !ahb_in.hwrite) begin
      next_hrdata = rd_mux(ahb_in.haddr[7:0], interrupt_enable_mask, timer_c_control_reg,
                           stat, ien, pwr);
    end
  end

  // One driver for the whole carrier; zero wait states and always OKAY
  assign ahb_out = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: hrdata};

  // Registers, timer flags, vector and machine cycle phase
  always_comb begin
    next_phase = (phase == PH_LAST) ? 4'h0 : 4'(phase + 4'h1);
    // Reserved bit 6 is never stored, so it reads zero whatever is written
    next_ie = wr_ie ? (ahb_in.hwdata[7:0] & IE_WMASK) : interrupt_enable_mask;
    next_ien = (ap_valid && ap_write && ap_addr == ADDR_IEN) ? ahb_in.hwdata[5:0] : ien;
    next_stat = stat;
    if (ap_valid && ap_write && ap_addr == ADDR_ICLR) begin
      next_stat = stat & ~ahb_in.hwdata[5:0];
    end
    // Sticky dispatch events; a set beats a clear in the same cycle
    next_stat = next_stat | disp;
    // Rollover events wait in pending bits for their setting phase
    next_ta_pend = ta_pend | timer_a_rollover;
    next_tb_pend = tb_pend | timer_b_rollover;
    next_tc_pend = tc_pend | timer_c_rollover;
    next_ta_flag = timer_a_overflow_flag;
    next_tb_flag = timer_b_overflow_flag;
    // Hardware clears A and B flags when the core takes their vector
    if (acked && vec_out.vector == SRC_TIMER_A) begin
      next_ta_flag = 1'b0;
    end
    if (acked && vec_out.vector == SRC_TIMER_B) begin
      next_tb_flag = 1'b0;
    end
    // Flags set at the poll edge are seen only by the next cycle's poll
    if (phase == PH_STATE5_PHASE2) begin
      next_ta_flag = next_ta_flag | ta_pend;
      next_tb_flag = next_tb_flag | tb_pend;
      next_ta_pend = timer_a_rollover;
      next_tb_pend = timer_b_rollover;
    end
    next_tcc = wr_tcc ? (ahb_in.hwdata[7:0] & TCC_WMASK) : timer_c_control_reg;
    // Set ahead of the poll in the same cycle
    if (phase == PH_STATE2_PHASE2) begin
      next_tc_pend = timer_c_rollover;
      if (tc_pend && !timer_c_control_reg[TCC_BAUD]) begin
        next_tcc[TCC_OVF] = 1'b1;
        if (timer_c_control_reg[TCC_UPDOWN]) begin
          next_tcc[TCC_EXT] = ~timer_c_control_reg[TCC_EXT];
        end
      end
    end
    // Pin edge counts only when the pin is not the count direction
    if (tc_fall && timer_c_control_reg[TCC_EXTEN] && !timer_c_control_reg[TCC_UPDOWN]) begin
      next_tcc[TCC_EXT] = 1'b1;
    end
    next_vec = vec_out;
    // Timer C flags are untouched when its vector is taken
    if (acked) begin
      next_vec.valid = 1'b0;
    end else if (disp != 6'h00) begin
      next_vec.valid = 1'b1;
      next_vec.vector = pick(enabled_req);
    end
  end

  // Power state; an interrupt can end idle but never power-down
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      SSIG_RUN: begin
        if (powerdown_request) begin
          next_pwr = SSIG_PDOWN;
        end else if (idle_request) begin
          next_pwr = SSIG_IDLE;
        end
      end
      SSIG_IDLE: begin
        if (enabled_req != 6'h00) begin
          next_pwr = SSIG_RUN;
        end
      end
      SSIG_PDOWN: begin
        next_pwr = SSIG_PDOWN;
      end
      default: begin
        next_pwr = SSIG_RUN;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 4'h0;
      interrupt_enable_mask <= IE_RESET;
      timer_c_control_reg <= TCC_RESET;
      stat <= STAT_RESET;
      ien <= STAT_RESET;
      ta_pend <= 1'b0;
      tb_pend <= 1'b0;
      tc_pend <= 1'b0;
      timer_a_overflow_flag <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
      vec_out <= '0;
      pwr <= SSIG_RUN;
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      phase <= next_phase;
      interrupt_enable_mask <= next_ie;
      timer_c_control_reg <= next_tcc;
      stat <= next_stat;
      ien <= next_ien;
      ta_pend <= next_ta_pend;
      tb_pend <= next_tb_pend;
      tc_pend <= next_tc_pend;
      timer_a_overflow_flag <= next_ta_flag;
      timer_b_overflow_flag <= next_tb_flag;
      vec_out <= next_vec;
      pwr <= next_pwr;
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
    end
  end

  // Outputs driven from state
  assign cpu_halted = (pwr != SSIG_RUN);
  assign osc_stopped = (pwr == SSIG_PDOWN);
  assign irq = |(stat & ien);

  // Checks beside the logic they guard
  sequence s_tc_edge;
    tc_fall && timer_c_control_reg[TCC_EXTEN] && !timer_c_control_reg[TCC_UPDOWN];
  endsequence

  sequence s_tc_taken;
    acked && vec_out.vector == SRC_TIMER_C && timer_c_control_reg[TCC_OVF] && !wr_tcc;
  endsequence

  AST_GLOBAL_GATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(vec_out.valid) |-> $past(interrupt_enable_mask[IE_GLOBAL]))
    else $error("vector issued with global enable low");
  AST_SOURCE_ENABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(vec_out.valid) |->
      (($past(interrupt_enable_mask[5:0]) >> vec_out.vector) & 6'h01) != 6'h00)
    else $error("vector issued for a disabled source");
  AST_VECTOR_HELD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    vec_out.valid && !core_ack |=> vec_out.valid && $stable(vec_out.vector))
    else $error("vector changed before it was taken");
  AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_tc_edge |=> timer_c_control_reg[TCC_EXT])
    else $error("external edge did not set timer C flag");
  AST_TC_KEPT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_tc_taken |=> timer_c_control_reg[TCC_OVF])
    else $error("timer C flag cleared by vectoring");
  AST_AB_PHASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(timer_a_overflow_flag) || $rose(timer_b_overflow_flag) |-> $past(phase) == PH_STATE5_PHASE2)
    else $error("timer A or B flag set off phase");
  AST_TC_PHASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(timer_c_control_reg[TCC_OVF]) && !$past(wr_tcc) |-> $past(phase) == PH_STATE2_PHASE2)
    else $error("timer C overflow flag set off phase");
  AST_BAUD_QUIET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(timer_c_control_reg[TCC_OVF]) |-> !$past(timer_c_control_reg[TCC_BAUD]) || $past(wr_tcc))
    else $error("baud mode rollover set overflow flag");
  AST_IDLE_WAKE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwr == SSIG_IDLE && enabled_req != 6'h00 |=> pwr == SSIG_RUN)
    else $error("idle not ended by enabled request");
  AST_PDOWN_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwr == SSIG_PDOWN |=> pwr == SSIG_PDOWN [*3])
    else $error("power-down left without reset");
endmodule

// ==== common/ssig_pkg.sv ====
// Constants, register map and carrier types of the six-source interrupt gate
package ssig_pkg;
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_IE = 8'h00;
  localparam logic [7:0] ADDR_TCC = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IEN = 8'h0C;
  localparam logic [7:0] ADDR_ICLR = 8'h10;
  localparam logic [7:0] ADDR_PWR = 8'h14;
  // Enable mask layout; source index equals its enable bit
  localparam int NUM_SRC = 6;
  localparam int IE_GLOBAL = 7;
  localparam logic [7:0] IE_WMASK = 8'hBF;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_TIMER_A = 3'h1;
  localparam logic [2:0] SRC_EXT_B = 3'h2;
  localparam logic [2:0] SRC_TIMER_B = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_TIMER_C = 3'h5;
  // Third timer control register layout
  localparam int TCC_OVF = 7;
  localparam int TCC_EXT = 6;
  localparam int TCC_BAUD = 4;
  localparam int TCC_EXTEN = 3;
  localparam int TCC_UPDOWN = 0;
  localparam logic [7:0] TCC_WMASK = 8'hD9;
  localparam logic [7:0] TCC_RESET = 8'h00;
  localparam logic [5:0] STAT_RESET = 6'h00;
  // Machine cycle: six states of two phases, one phase per clock
  localparam logic [3:0] PH_LAST = 4'hB;
  localparam logic [3:0] PH_STATE2_PHASE2 = 4'h3;
  localparam logic [3:0] PH_STATE5_PHASE2 = 4'h9;
  // Power state, Gray coded along run -> idle -> power-down
  typedef enum logic [1:0] {
    SSIG_RUN = 2'b00,
    SSIG_IDLE = 2'b01,
    SSIG_PDOWN = 2'b11
  } ssig_pwr_t;
  // AHB-Lite slave inputs and outputs
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ssig_ahb_in_t;
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ssig_ahb_out_t;
  // Vector offered to the core sequencer
  typedef struct packed {
    logic valid;
    logic [2:0] vector;
  } ssig_vec_t;
endpackage

// ==== testbench/ssig_core_model.sv ====
// Core sequencer model that takes offered vectors after a set delay
`timescale 1ns/10ps
module ssig_core_model (
  input wire logic sys_clk, // Core clock
  input wire logic sys_rst, // Reset, active high
  input wire ssig_pkg::ssig_vec_t vec_in, // Vector offered by the gate
  input wire logic [3:0] ack_wait, // Cycles to wait before taking
  output logic core_ack, // One-cycle take strobe
  output logic [2:0] taken_vector, // Last vector taken
  output logic [7:0] taken_count // Vectors taken so far
);
  import ssig_pkg::*;
  logic [3:0] wait_cnt;
  // One strobe per offer; the strobe drops at once so a held offer is never taken twice
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ack <= 1'h0;
      taken_vector <= 3'h0;
      taken_count <= 8'h0;
      wait_cnt <= 4'h0;
    end else if (core_ack) begin
      core_ack <= 1'h0;
      taken_vector <= vec_in.vector;
      taken_count <= taken_count + 8'h1;
      wait_cnt <= 4'h0;
    end else if (vec_in.valid) begin
      if (wait_cnt == ack_wait) begin
        core_ack <= 1'h1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// ==== testbench/six_source_interrupt_gate_tb_top.sv ====
// Self-checking bench for the six-source interrupt gate
`timescale 1ns/10ps
module six_source_interrupt_gate_tb_top;
  import ssig_pkg::*;
  logic sys_clk, core_ack, cpu_halted, osc_stopped, irq;
  logic sys_rst = 1'h1, line_a_n = 1'h1, line_b_n = 1'h1, tcx = 1'h1;
  logic ta = 1'h0, tb = 1'h0, tc = 1'h0, ser = 1'h0, idle_rq = 1'h0, pd_rq = 1'h0;
  logic b_trans = 1'h0, b_wr = 1'h0;
  logic [7:0] b_addr = 8'h0;
  logic [31:0] b_wdata = 32'h0, rd;
  logic [3:0] ack_wait = 4'h0;
  logic [2:0] taken_vector;
  logic [7:0] taken_count;
  ssig_ahb_in_t ahb_in;
  ssig_ahb_out_t ahb_out;
  ssig_vec_t vec_out;
  int n_fail = 0, comparisons = 0, cyc = 0;
  // Single slave, so its hreadyout is the bus hready
  assign ahb_in = '{1'h1, {24'h0, b_addr}, {b_trans, 1'h0}, b_wr, 3'h2, ahb_out.hreadyout, b_wdata};
  ssig_gate uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ahb_in(ahb_in), .ahb_out(ahb_out),
    .ext_request_line_a_n(line_a_n), .ext_request_line_b_n(line_b_n),
    .timer_c_external_input(tcx), .timer_a_rollover(ta), .timer_b_rollover(tb),
    .timer_c_rollover(tc), .serial_request(ser), .idle_request(idle_rq),
    .powerdown_request(pd_rq), .core_ack(core_ack), .vec_out(vec_out),
    .cpu_halted(cpu_halted), .osc_stopped(osc_stopped), .irq(irq));
  ssig_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .vec_in(vec_out),
    .ack_wait(ack_wait), .core_ack(core_ack), .taken_vector(taken_vector),
    .taken_count(taken_count));
  // 100 ns clock
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("%0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask
  // One single transfer; the request stands until hready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    b_trans <= 1'h1;
    b_addr <= a;
    b_wr <= w;
    do @(posedge sys_clk); while (ahb_out.hreadyout !== 1'h1);
    b_trans <= 1'h0;
    b_wdata <= d;
    do @(posedge sys_clk); while (ahb_out.hreadyout !== 1'h1);
    rd = ahb_out.hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
    chk(32'(ahb_out.hresp), 32'h0);
  endtask
  // Wait for the core model to take one vector and compare it
  task take(input logic [2:0] v);
    logic [7:0] c0;
    c0 = taken_count;
    for (int i = 0; i < 80 && taken_count === c0; i++) @(negedge sys_clk);
    chk(32'(taken_count), 32'(c0 + 8'h1));
    chk(32'(taken_vector), 32'(v));
  endtask
  // Three full polls pass, long enough for any wrongly admitted request
  task none();
    logic [7:0] c0;
    c0 = taken_count;
    repeat (40) @(negedge sys_clk);
    chk(32'(taken_count), 32'(c0));
  endtask
  // Raise or drop source s; lines are active low, the rest active high
  task kick(input int s, input logic v);
    case (s)
      0: line_a_n <= ~v;
      1: ta <= v;
      2: line_b_n <= ~v;
      3: tb <= v;
      4: ser <= v;
      default: tc <= v;
    endcase
  endtask
  task t_regs();
    logic [7:0] adr [6] = '{ADDR_IE, ADDR_TCC, ADDR_STAT, ADDR_IEN, ADDR_PWR, 8'h18};
    foreach (adr[i]) rdc(adr[i], 32'h0);
    wr(ADDR_IE, 32'hBF);
    rdc(ADDR_IE, 32'hBF);
    wr(8'h18, 32'hFFFFFFFF);
    rdc(8'h18, 32'h0);
    wr(ADDR_STAT, 32'h3F);
    rdc(ADDR_STAT, 32'h0);
    wr(ADDR_IE, 32'h0);
    $display("registers finished");
  endtask
  // Each source alone, with only its own enable and the global gate set
  task t_src();
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_IE, 32'h80 | (32'h1 << s));
      @(posedge sys_clk);
      kick(s, 1'h1);
      @(posedge sys_clk);
      if (s % 2 == 1)
        kick(s, 1'h0);
      take(3'(s));
      @(posedge sys_clk);
      kick(s, 1'h0);
      wr(ADDR_IE, 32'h0);
      wr(ADDR_TCC, 32'h0);
    end
    $display("sources finished");
  endtask
  task t_gate();
    @(posedge sys_clk);
    ser <= 1'h1;
    wr(ADDR_IE, 32'h3F);
    none();
    wr(ADDR_IE, 32'hAF);
    none();
    @(posedge sys_clk);
    line_a_n <= 1'h0;
    ack_wait <= 4'hD;
    wr(ADDR_IE, 32'hBF);
    take(3'h0);
    @(posedge sys_clk);
    line_a_n <= 1'h1;
    take(3'h4);
    @(posedge sys_clk);
    ser <= 1'h0;
    ack_wait <= 4'h0;
    wr(ADDR_IE, 32'h0);
    $display("gating finished");
  endtask
  // A serial vector marks the poll phase; the timer pulse follows it
  task lat(input int s, input int exp);
    int n;
    wr(ADDR_IE, 32'hBA);
    @(posedge sys_clk);
    ser <= 1'h1;
    n = 0;
    while (vec_out.valid !== 1'h1 && n < 80) @(negedge sys_clk) n++;
    @(posedge sys_clk);
    ser <= 1'h0;
    kick(s, 1'h1);
    @(posedge sys_clk);
    kick(s, 1'h0);
    // Count edges since the marking poll; the vector is only looked at on falling edges
    n = 1;
    do @(negedge sys_clk) n++; while (vec_out.valid === 1'h1 && n < 80);
    while (vec_out.valid !== 1'h1 && n < 80) @(negedge sys_clk) n++;
    chk(n, exp);
    wr(ADDR_IE, 32'h0);
    wr(ADDR_TCC, 32'h0);
    $display("latency finished");
  endtask
  task t_tc();
    wr(ADDR_ICLR, 32'h3F);
    wr(ADDR_TCC, 32'h08);
    wr(ADDR_IE, 32'hA0);
    @(posedge sys_clk);
    tcx <= 1'h0;
    take(3'h5);
    wr(ADDR_IE, 32'h0);
    rdc(ADDR_TCC, 32'h48);
    rdc(ADDR_STAT, 32'h20);
    wr(ADDR_IEN, 32'h20);
    repeat (2) @(negedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(ADDR_ICLR, 32'h20);
    repeat (2) @(negedge sys_clk);
    chk(32'(irq), 32'h0);
    rdc(ADDR_STAT, 32'h0);
    @(posedge sys_clk);
    tcx <= 1'h1;
    wr(ADDR_TCC, 32'h10);
    wr(ADDR_IE, 32'hA0);
    kick(5, 1'h1);
    @(posedge sys_clk);
    kick(5, 1'h0);
    none();
    rdc(ADDR_TCC, 32'h10);
    wr(ADDR_TCC, 32'h41);
    none();
    wr(ADDR_IE, 32'h0);
    wr(ADDR_TCC, 32'h0);
    $display("timer c finished");
  endtask
  task t_pwr();
    wr(ADDR_IE, 32'h90);
    @(posedge sys_clk);
    idle_rq <= 1'h1;
    @(posedge sys_clk);
    idle_rq <= 1'h0;
    repeat (2) @(negedge sys_clk);
    chk(32'(cpu_halted), 32'h1);
    rdc(ADDR_PWR, 32'h1);
    rdc(ADDR_IE, 32'h90);
    @(posedge sys_clk);
    ser <= 1'h1;
    take(3'h4);
    chk(32'(cpu_halted), 32'h0);
    @(posedge sys_clk);
    ser <= 1'h0;
    pd_rq <= 1'h1;
    @(posedge sys_clk);
    pd_rq <= 1'h0;
    ser <= 1'h1;
    none();
    chk(32'(osc_stopped), 32'h1);
    chk(32'(cpu_halted), 32'h1);
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    ser <= 1'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
    chk(32'(cpu_halted), 32'h0);
    chk(32'(osc_stopped), 32'h0);
    $display("power finished");
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    t_regs();
    t_src();
    t_gate();
    lat(5, 12);
    lat(1, 24);
    lat(3, 24);
    t_tc();
    t_pwr();
    print_verdict();
  end
endmodule
